// ---- mmr_pkg.sv ----
// Constants and types for the memory map remap decoder
package mmr_pkg;
    localparam int          ADDR_W         = 32;
    localparam logic [31:0] INT_MEM_TOP    = 32'h0040_0000;
    localparam logic [31:0] EXT_TOP        = 32'hFFC0_0000;
    localparam int          SRAM_BYTES     = 262144;
    localparam int          SRAM_AW        = 16;
    localparam int          STRAP_CYCLES   = 10;
    localparam logic [3:0]  STRAP_CNT_W1   = 4'h9;
    localparam int          RST_SYNC_DEPTH = 2;
    localparam int          NUM_BANKS      = 8;
    localparam int          WAIT_W         = 3;
    localparam int          FLOAT_W        = 2;
    localparam logic [31:0] BANK_1M_MASK   = 32'h000F_FFFF;
    localparam logic [31:0] BANK_16M_MASK  = 32'h00FF_FFFF;
    localparam logic [31:0] BANK_BASE_RST  = 32'h0040_0000;
    localparam logic [1:0]  SIZE_BYTE      = 2'h0;
    localparam logic [1:0]  SIZE_HALF      = 2'h1;
    localparam logic [1:0]  SIZE_WORD      = 2'h2;

    typedef enum logic [1:0] {
        MMR_REG_INT = 2'b00,
        MMR_REG_EXT = 2'b01,
        MMR_REG_PER = 2'b11
    } mmr_region_e;
endpackage

// ---- mmr_sram.sv ----
// Internal single-cycle 32-bit SRAM with byte lanes
`timescale 1ns/100ps
`default_nettype none
module mmr_sram #(
    parameter int AW = 16
) (
    // Clock
    input  wire logic          clk_sys,
    // Access
    input  wire logic          en,
    input  wire logic          we,
    input  wire logic [3:0]    be,
    input  wire logic [AW-1:0] idx,
    input  wire logic [31:0]   wdata,
    output logic      [31:0]   rdata
);
    logic [31:0] mem [0:(1<<AW)-1];

    // Enabled lanes written, or whole word read, in one cycle
    always_ff @(posedge clk_sys) begin
        if (en && we) begin
            for (int i = 0; i < 4; i++) begin
                if (be[i]) begin
                    mem[idx][i*8 +: 8] <= wdata[i*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (en && !we) begin
            rdata <= mem[idx];
        end
    end
endmodule
`default_nettype wire

// ---- mmr_decoder.sv ----
// Memory map decoder with boot strap, remap, abort and bank settings
// What this block does
// R1: Split address into memory, external, peripheral.
// R2: Route 0x0040_0000 to 0xFFC0_0000 externally.
// R3: Little-endian byte lanes everywhere.
// R4: SRAM completes any size in one cycle.
// R5: After remap, SRAM sits at zero.
// R6: Boot strap sampled last 10 cycles before release.
// R7: Strap one: 8-bit boot; zero: 16-bit.
// R8: Writing remap bit swaps boot memory, SRAM.
// R9: Software remaps before using chip selects 1-7.
// R10: Remap persists until any reset.
// R11: Abort on undefined external-region address.
// R12: No abort for memory or peripherals.
// R13: Eight banks, each 1M or 16M.
// R14: Per-bank wait, float count, width.
// R15: 16-bit banks: byte select or write strobes.
// R16: Optional early read for all devices.
// R17: Accept aligned byte, half, word accesses.
// R18: Flash addressed in halfwords on A1-A20.
// R19: Watchdog reset keeps latched boot mode.
// R20: Async reset assert, synchronous release.
// R21: Every reset clears remap.
`timescale 1ns/100ps
`default_nettype none
module mmr_decoder
    import mmr_pkg::*;
#(
    parameter int NBANK = mmr_pkg::NUM_BANKS,
    parameter int AW    = mmr_pkg::SRAM_AW
) (
    // Clock and resets
    input  wire logic                      clk_sys,
    input  wire logic                      srst,
    input  wire logic                      external_reset_n,
    input  wire logic                      watchdog_reset,
    // Boot strap
    input  wire logic                      boot_width_select,
    // Processor access
    input  wire logic                      cpu_req,
    input  wire logic                      cpu_we,
    input  wire logic                      cpu_fetch,
    input  wire logic [1:0]                cpu_size,
    input  wire logic [31:0]               cpu_addr,
    input  wire logic [31:0]               cpu_wdata,
    output logic      [31:0]               cpu_rdata,
    output logic                           cpu_ready,
    output logic                           data_abort,
    output logic                           prefetch_abort,
    // Remap control, boot mode and core reset
    input  wire logic                      remap_control_reg_wr,
    input  wire logic                      remap_bit,
    output logic                           remap_active,
    output logic                           boot_8bit,
    output logic                           core_rst,
    // Bank configuration
    input  wire logic                      bank_cfg_wr,
    input  wire logic [2:0]                bank_cfg_idx,
    input  wire logic [31:0]               bank_cfg_base,
    input  wire logic                      bank_cfg_big,
    input  wire logic                      bank_cfg_en,
    input  wire logic [mmr_pkg::WAIT_W-1:0]  bank_cfg_wait,
    input  wire logic [mmr_pkg::FLOAT_W-1:0] bank_cfg_float,
    input  wire logic                      bank_cfg_w16,
    input  wire logic                      bank_cfg_bwr,
    input  wire logic                      early_read_en,
    // External bus request
    output logic                           ext_req,
    output logic      [7:0]                ext_cs,
    output logic      [31:0]               ext_addr,
    output logic      [3:0]                ext_be,
    output logic                           ext_we,
    output logic      [mmr_pkg::WAIT_W-1:0]  ext_wait,
    output logic      [mmr_pkg::FLOAT_W-1:0] ext_float,
    output logic                           ext_w16,
    output logic                           ext_bwr,
    output logic                           ext_early,
    output logic      [20:1]               flash_addr,
    input  wire logic                      ext_done,
    input  wire logic [31:0]               ext_rdata,
    // Peripheral request
    output logic                           per_req,
    output logic      [31:0]               per_addr,
    input  wire logic [31:0]               per_rdata
);
    import mmr_pkg::*;

    // Region decode, used only on the live cpu_addr path
    function automatic mmr_region_e region_of(input logic [31:0] a);
        if (a < INT_MEM_TOP) begin
            region_of = MMR_REG_INT;                     // [R1]
        end else if (a < EXT_TOP) begin
            region_of = MMR_REG_EXT;                     // [R2]
        end else begin
            region_of = MMR_REG_PER;
        end
    endfunction

    // Little-endian lane enables
    function automatic logic [3:0] lanes_of(input logic [1:0] sz,
                                            input logic [1:0] a);
        if (sz == SIZE_BYTE) begin
            lanes_of = 4'h1 << a;                        // [R3]
        end else if (sz == SIZE_HALF) begin
            lanes_of = a[1] ? 4'hC : 4'h3;
        end else begin
            lanes_of = 4'hF;
        end
    endfunction

    // Reset release synchroniser
    logic       rst_s1_r;
    logic       rst_s2_r;
    logic       ext_rst_r;
    always_ff @(posedge clk_sys or negedge external_reset_n) begin
        if (!external_reset_n) begin
            rst_s1_r <= 1'b1;                            // [R20]
            rst_s2_r <= 1'b1;
        end else begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= rst_s1_r;
        end
    end
    always_ff @(posedge clk_sys) begin
        ext_rst_r <= rst_s2_r | srst;
    end

    logic int_rst;
    assign int_rst = ext_rst_r | watchdog_reset;

    always_ff @(posedge clk_sys) begin
        core_rst <= int_rst;
    end

    // Strap shift: last 10 samples before release
    logic [STRAP_CYCLES-1:0] strap_hist_r;
    always_ff @(posedge clk_sys) begin
        if (ext_rst_r) begin
            strap_hist_r <= {strap_hist_r[STRAP_CYCLES-2:0],
                             boot_width_select};         // [R6]
        end
    end

    // Boot mode tracks the strap only under external reset,
    // so bank 0 width resets to the mode being latched
    logic boot_8bit_nxt;
    always_comb begin
        boot_8bit_nxt = ext_rst_r ? strap_hist_r[0] : boot_8bit;
    end
    always_ff @(posedge clk_sys) begin
        boot_8bit <= boot_8bit_nxt;                      // [R7]
    end
    // Watchdog resets never reach the strap latch       [R19]

    // Remap state
    always_ff @(posedge clk_sys) begin
        if (int_rst) begin
            remap_active <= 1'b0;                        // [R10] [R21]
        end else if (remap_control_reg_wr && remap_bit) begin
            remap_active <= 1'b1;                        // [R8]
        end
    end

    // Bank settings
    logic [31:0]        bank_base_r  [NBANK];
    logic [NBANK-1:0]   bank_big_r;
    logic [NBANK-1:0]   bank_en_r;
    logic [WAIT_W-1:0]  bank_wait_r  [NBANK];
    logic [FLOAT_W-1:0] bank_float_r [NBANK];
    logic [NBANK-1:0]   bank_w16_r;
    logic [NBANK-1:0]   bank_bwr_r;
    logic               early_r;

    genvar g;
    generate
        for (g = 0; g < NBANK; g++) begin : g_bank
            always_ff @(posedge clk_sys) begin
                if (int_rst) begin
                    bank_base_r[g]  <= BANK_BASE_RST;
                    bank_big_r[g]   <= 1'b0;
                    bank_en_r[g]    <= (g == 0);
                    bank_wait_r[g]  <= '1;
                    bank_float_r[g] <= '0;
                    bank_w16_r[g]   <= (g == 0) ? ~boot_8bit_nxt : 1'b0;
                    bank_bwr_r[g]   <= 1'b0;
                end else if (bank_cfg_wr &&
                             bank_cfg_idx == 3'(g)) begin
                    bank_base_r[g]  <= bank_cfg_base;    // [R13]
                    bank_big_r[g]   <= bank_cfg_big;
                    bank_en_r[g]    <= bank_cfg_en;
                    bank_wait_r[g]  <= bank_cfg_wait;    // [R14]
                    bank_float_r[g] <= bank_cfg_float;
                    bank_w16_r[g]   <= bank_cfg_w16;
                    bank_bwr_r[g]   <= bank_cfg_w16 &
                                       bank_cfg_bwr;     // [R15]
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (int_rst) begin
            early_r <= 1'b0;
        end else begin
            early_r <= early_read_en;                    // [R16]
        end
    end

    // Bank hit: chip selects 1..7 usable only after remap
    logic [NBANK-1:0] hit;
    always_comb begin
        hit = '0;
        for (int i = 0; i < NBANK; i++) begin
            if (bank_en_r[i] && (i == 0 || remap_active)) begin   // [R9]
                if (bank_big_r[i]) begin
                    hit[i] = (cpu_addr & ~BANK_16M_MASK) ==
                             (bank_base_r[i] & ~BANK_16M_MASK);
                end else begin
                    hit[i] = (cpu_addr & ~BANK_1M_MASK) ==
                             (bank_base_r[i] & ~BANK_1M_MASK);
                end
            end
        end
    end

    // Low-address selection: boot memory until remap
    mmr_region_e reg_now;
    logic        low_boot;
    logic [2:0]  hit_idx;
    logic        any_hit;
    logic        aligned;
    always_comb begin
        reg_now  = region_of(cpu_addr);
        low_boot = (reg_now == MMR_REG_INT) && !remap_active;  // [R5]
        any_hit  = low_boot || (hit != '0);
        hit_idx  = 3'h0;
        for (int i = NBANK-1; i >= 0; i--) begin
            if (hit[i]) begin
                hit_idx = 3'(i);
            end
        end
        aligned = (cpu_size == SIZE_BYTE) ||
                  (cpu_size == SIZE_HALF && !cpu_addr[0]) ||
                  (cpu_size == SIZE_WORD && cpu_addr[1:0] == 2'h0);
    end

    // Access sequencing
    logic        sram_en;
    logic [31:0] sram_rdata;
    logic        busy_r;
    logic        sram_rd_r;
    logic        per_rd_r;

    assign sram_en = cpu_req && !busy_r && !int_rst &&
                     reg_now == MMR_REG_INT && remap_active;

    mmr_sram #(
        .AW (AW)
    ) u_sram (
        .clk_sys (clk_sys),
        .en      (sram_en),
        .we      (cpu_we),
        .be      (lanes_of(cpu_size, cpu_addr[1:0])),
        .idx     (cpu_addr[AW+1:2]),
        .wdata   (cpu_wdata),
        .rdata   (sram_rdata)
    );

    always_ff @(posedge clk_sys) begin
        if (int_rst) begin
            busy_r         <= 1'b0;
            sram_rd_r      <= 1'b0;
            per_rd_r       <= 1'b0;
            cpu_ready      <= 1'b0;
            data_abort     <= 1'b0;
            prefetch_abort <= 1'b0;
            ext_req        <= 1'b0;
            per_req        <= 1'b0;
            ext_cs         <= '0;
            ext_addr       <= '0;
            ext_be         <= '0;
            ext_we         <= 1'b0;
            ext_wait       <= '0;
            ext_float      <= '0;
            ext_w16        <= 1'b0;
            ext_bwr        <= 1'b0;
            ext_early      <= 1'b0;
            flash_addr     <= '0;
            per_addr       <= '0;
            cpu_rdata      <= '0;
        end else begin
            cpu_ready      <= 1'b0;
            data_abort     <= 1'b0;
            prefetch_abort <= 1'b0;
            per_req        <= 1'b0;
            sram_rd_r      <= 1'b0;
            per_rd_r       <= 1'b0;
            if (sram_rd_r) begin
                cpu_rdata <= sram_rdata;
            end
            if (per_rd_r) begin
                cpu_rdata <= per_rdata;
            end
            if (busy_r) begin
                if (ext_done) begin
                    busy_r    <= 1'b0;
                    ext_req   <= 1'b0;
                    cpu_ready <= 1'b1;
                    cpu_rdata <= ext_rdata;
                end
            end else if (cpu_req) begin
                if (sram_en) begin
                    cpu_ready <= 1'b1;                   // [R4]
                    sram_rd_r <= !cpu_we;
                end else if (reg_now == MMR_REG_PER) begin
                    per_req   <= 1'b1;                   // [R12]
                    per_addr  <= {cpu_addr[31:2], 2'h0};
                    per_rd_r  <= !cpu_we;
                    cpu_ready <= 1'b1;
                end else if (any_hit && aligned) begin   // [R17]
                    busy_r    <= 1'b1;
                    ext_req   <= 1'b1;
                    ext_cs    <= 8'h1 << hit_idx;
                    ext_addr  <= cpu_addr;
                    ext_be    <= lanes_of(cpu_size, cpu_addr[1:0]);
                    ext_we    <= cpu_we;
                    ext_wait  <= bank_wait_r[hit_idx];
                    ext_float <= bank_float_r[hit_idx];
                    ext_w16   <= bank_w16_r[hit_idx];
                    ext_bwr   <= bank_bwr_r[hit_idx];
                    ext_early <= early_r;
                    flash_addr <= cpu_addr[20:1];        // [R18]
                end else begin
                    cpu_ready      <= 1'b1;
                    data_abort     <= !cpu_fetch;        // [R11]
                    prefetch_abort <= cpu_fetch;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- mmr_monitor.sv ----
// Port checker for the memory map remap decoder
`timescale 1ns/100ps
`default_nettype none
module mmr_monitor (
    // Clock and resets
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        core_rst,
    input wire logic        external_reset_n,
    input wire logic        watchdog_reset,
    // Processor side
    input wire logic        cpu_req,
    input wire logic [31:0] cpu_addr,
    input wire logic        cpu_ready,
    input wire logic        data_abort,
    input wire logic        prefetch_abort,
    // Remap
    input wire logic        remap_control_reg_wr,
    input wire logic        remap_bit,
    input wire logic        remap_active,
    // Far side
    input wire logic        ext_req,
    input wire logic        ext_done,
    input wire logic [7:0]  ext_cs,
    input wire logic [31:0] ext_addr,
    input wire logic        per_req,
    input wire logic [31:0] per_addr
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst || core_rst);
    chk_abort_ready: assert property ((data_abort || prefetch_abort)
        |-> cpu_ready) else $error("abort without ready");
    chk_per_noabort: assert property (per_req
        |-> !(data_abort || prefetch_abort)) else $error("peripheral abort");
    chk_ext_range: assert property (ext_req |->
        (ext_addr >= 32'h0040_0000 && ext_addr < 32'hFFC0_0000) ||
        (ext_addr < 32'h0040_0000 && ext_cs == 8'h01 && !remap_active))
        else $error("external outside range");
    chk_per_region: assert property (per_req |->
        per_addr >= 32'hFFC0_0000 && per_addr[1:0] == 2'h0)
        else $error("peripheral address bad");
    chk_boot_low: assert property (cpu_req && !cpu_ready && !ext_req
        && !remap_active && cpu_addr < 32'h0040_0000
        && cpu_addr[1:0] == 2'h0 |=> ext_req && ext_cs == 8'h01)
        else $error("boot memory not at zero");
    chk_cs_onehot: assert property (ext_req |-> $onehot(ext_cs))
        else $error("chip select not one-hot");
    chk_remap_set: assert property (remap_control_reg_wr && remap_bit
        && external_reset_n && !watchdog_reset |=> remap_active)
        else $error("remap not set");
    chk_remap_hold: assert property (remap_active && external_reset_n
        && !watchdog_reset |=> remap_active) else $error("remap lost");
    chk_ext_answer: assert property (ext_req && ext_done
        |=> cpu_ready && !ext_req) else $error("external answer late");
    chk_sram_one: assert property (cpu_req && !cpu_ready && !ext_req
        && remap_active && cpu_addr < 32'h0040_0000 |=> cpu_ready)
        else $error("sram not single cycle");
endmodule
bind mmr_decoder mmr_monitor mon_u (.clk_sys, .srst, .core_rst,
    .external_reset_n, .watchdog_reset, .cpu_req, .cpu_addr, .cpu_ready,
    .data_abort, .prefetch_abort, .remap_control_reg_wr, .remap_bit,
    .remap_active, .ext_req, .ext_done, .ext_cs, .ext_addr, .per_req,
    .per_addr);
`default_nettype wire

// ---- mmr_ext_model.sv ----
// External device model answering after the programmed wait count
`timescale 1ns/100ps
`default_nettype none
module mmr_ext_model
    import mmr_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      srst,
    // Bus
    input  wire logic                      ext_req,
    input  wire logic [31:0]               ext_addr,
    input  wire logic [mmr_pkg::WAIT_W-1:0] ext_wait,
    output logic                           ext_done,
    output logic      [31:0]               ext_rdata
);
    logic [WAIT_W-1:0] cnt_r;
    always_ff @(posedge clk_sys) begin
        ext_done <= 1'b0;
        if (srst || !ext_req || ext_done) begin
            cnt_r <= '0;
        end else if (cnt_r == ext_wait) begin
            ext_done <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
    // Data only valid with done, toggles otherwise
    always_ff @(posedge clk_sys) begin
        if (ext_req && !ext_done && cnt_r == ext_wait) begin
            ext_rdata <= 32'hA5A5_0000 ^ ext_addr;
        end else begin
            ext_rdata <= ~ext_rdata;
        end
    end
endmodule
`default_nettype wire

// ---- mmr_decoder_test.sv ----
// Self-checking bench for the memory map remap decoder
`timescale 1ns/100ps
`default_nettype none
module mmr_decoder_test;
    import mmr_pkg::*;
    typedef struct packed {
        logic        we;
        logic [1:0]  sz;
        logic [31:0] addr;
        logic [31:0] wd;
        logic [31:0] exp;
        logic        ab;
    } mmr_row_s;
    logic clk_sys = 0, srst = 1, external_reset_n = 1, watchdog_reset = 0;
    logic boot_width_select = 1, cpu_req = 0, cpu_we = 0, cpu_fetch = 0;
    logic [1:0] cpu_size = 0, bank_cfg_float = 0;
    logic [31:0] cpu_addr = 0, cpu_wdata = 0, bank_cfg_base = 0;
    logic remap_control_reg_wr = 0, remap_bit = 0, bank_cfg_wr = 0;
    logic bank_cfg_big = 0, bank_cfg_en = 0, bank_cfg_w16 = 0;
    logic bank_cfg_bwr = 0, early_read_en = 0, ext_done, ext_req, ext_we;
    logic [2:0] bank_cfg_idx = 0, bank_cfg_wait = 0, ext_wait, wait_s;
    logic [31:0] per_rdata = 32'h5A5A_C3C3, cpu_rdata, ext_rdata, ext_addr;
    logic [31:0] per_addr, rd;
    logic cpu_ready, data_abort, prefetch_abort, remap_active, boot_8bit;
    logic core_rst, ext_w16, ext_bwr, ext_early, per_req, ab, pa;
    logic w16_s, bwr_s, early_s, we_s;
    logic [7:0] ext_cs, cs_s;
    logic [3:0] ext_be, be_s;
    logic [1:0] ext_float, float_s;
    logic [20:1] flash_addr, fa_s;
    int errors = 0, comparisons = 0;
    mmr_row_s rows[10] = '{
        '{1'h1, SIZE_WORD, 32'h0000_0000, 32'h1122_3344, 32'h0, 1'h0},
        '{1'h0, SIZE_WORD, 32'h0000_0000, 32'h0, 32'h1122_3344, 1'h0},
        '{1'h1, SIZE_WORD, 32'h0000_0004, 32'h0, 32'h0, 1'h0},
        '{1'h1, SIZE_BYTE, 32'h0000_0005, 32'h7777_7777, 32'h0, 1'h0},
        '{1'h1, SIZE_HALF, 32'h0000_0006, 32'hBBBB_BBBB, 32'h0, 1'h0},
        '{1'h0, SIZE_WORD, 32'h0000_0004, 32'h0, 32'hBBBB_7700, 1'h0},
        '{1'h0, SIZE_WORD, 32'h0040_0010, 32'h0, 32'hA5E5_0010, 1'h0},
        '{1'h0, SIZE_WORD, 32'h0800_0000, 32'h0, 32'h0, 1'h1},
        '{1'h0, SIZE_BYTE, 32'hFFFF_F001, 32'h0, 32'h5A5A_C3C3, 1'h0},
        '{1'h0, SIZE_WORD, 32'h0040_0002, 32'h0, 32'h0, 1'h1}};

    mmr_decoder dut_u (.clk_sys, .srst, .external_reset_n, .watchdog_reset,
        .boot_width_select, .cpu_req, .cpu_we, .cpu_fetch, .cpu_size,
        .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_ready, .data_abort,
        .prefetch_abort, .remap_control_reg_wr, .remap_bit, .remap_active,
        .boot_8bit, .core_rst, .bank_cfg_wr, .bank_cfg_idx, .bank_cfg_base,
        .bank_cfg_big, .bank_cfg_en, .bank_cfg_wait, .bank_cfg_float,
        .bank_cfg_w16, .bank_cfg_bwr, .early_read_en, .ext_req, .ext_cs,
        .ext_addr, .ext_be, .ext_we, .ext_wait, .ext_float, .ext_w16,
        .ext_bwr, .ext_early, .flash_addr, .ext_done, .ext_rdata, .per_req,
        .per_addr, .per_rdata);
    mmr_ext_model ext_u (.clk_sys, .srst, .ext_req, .ext_addr, .ext_wait,
        .ext_done, .ext_rdata);

    always #5 clk_sys = ~clk_sys;
    // Keep what the last external access carried
    always @(posedge clk_sys) if (ext_req) begin
        {cs_s, w16_s, bwr_s, early_s} <= {ext_cs, ext_w16, ext_bwr, ext_early};
        {wait_s, float_s, fa_s} <= {ext_wait, ext_float, flash_addr};
        {be_s, we_s} <= {ext_be, ext_we};
    end

    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic access(input logic we, input logic [1:0] sz,
                          input logic [31:0] a, wd);
        int n;
        @(negedge clk_sys);
        {cpu_we, cpu_size, cpu_addr} = {we, sz, a};
        {cpu_wdata, cpu_req} = {wd, 1'b1};
        for (n = 0; n < 60 && cpu_ready !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        ab = data_abort | prefetch_abort;
        pa = prefetch_abort;
        if (n == 60) errors++;
        @(negedge clk_sys);
        cpu_req = 0;
        @(posedge clk_sys);
        #1 rd = cpu_rdata;
    endtask
    task automatic remap(input logic b);
        @(negedge clk_sys);
        {remap_control_reg_wr, remap_bit} = {1'b1, b};
        @(negedge clk_sys);
        remap_control_reg_wr = 0;
        @(negedge clk_sys);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        give_verdict;
    end
    initial begin
        repeat (10) @(negedge clk_sys);
        srst = 0;
        repeat (4) @(negedge clk_sys);
        check("boot_8bit", boot_8bit, 1);
        check("remap", remap_active, 0);
        cpu_fetch = 1;
        access(0, SIZE_WORD, 32'h0000_0010, 0);
        @(negedge clk_sys);
        cpu_fetch = 0;
        check("boot cs", cs_s, 8'h01);
        check("boot w16", w16_s, 0);
        remap(0);
        check("remap zero", remap_active, 0);
        remap(1);
        check("remap one", remap_active, 1);
        foreach (rows[i]) begin
            access(rows[i].we, rows[i].sz, rows[i].addr, rows[i].wd);
            check("abort", ab, rows[i].ab);
            if (!rows[i].we && !rows[i].ab)
                check("rdata", rd, rows[i].exp);
        end
        @(negedge clk_sys);
        cpu_fetch = 1;
        access(0, SIZE_WORD, 32'h0800_0000, 0);
        check("prefetch abort", pa, 1);
        @(negedge clk_sys);
        cpu_fetch = 0;
        // Bank one: 16M at 0x0100_0000, slow device, only after remap
        @(negedge clk_sys);
        {bank_cfg_wr, bank_cfg_idx, bank_cfg_base, bank_cfg_big} =
            {1'b1, 3'h1, 32'h0100_0000, 1'b1};
        {bank_cfg_en, bank_cfg_wait, bank_cfg_float} = {1'b1, 3'h2, 2'h1};
        {bank_cfg_w16, bank_cfg_bwr, early_read_en} = 3'h7;
        @(negedge clk_sys);
        bank_cfg_wr = 0;
        access(0, SIZE_WORD, 32'h0180_0004, 0);
        check("bank cs", cs_s, 8'h02);
        check("wait", wait_s, 3'h2);
        check("float", float_s, 2'h1);
        check("bwr", {w16_s, bwr_s}, 2'h3);
        check("early", early_s, 1);
        check("flash addr", fa_s, 20'h0_0002);
        access(1, SIZE_BYTE, 32'h0180_0003, 32'h5500_0000);
        check("ext be", be_s, 4'h8);
        check("ext we", we_s, 1);
        @(negedge clk_sys);
        boot_width_select = 0;
        watchdog_reset = 1;
        repeat (3) @(negedge clk_sys);
        watchdog_reset = 0;
        repeat (6) @(negedge clk_sys);
        check("wd boot", boot_8bit, 1);
        check("wd remap", remap_active, 0);
        remap(1);
        boot_width_select = 1;
        external_reset_n = 0;
        repeat (2) @(negedge clk_sys);
        boot_width_select = 0;
        repeat (12) @(negedge clk_sys);
        external_reset_n = 1;
        repeat (6) @(negedge clk_sys);
        check("rst boot", boot_8bit, 0);
        check("rst remap", remap_active, 0);
        check("core_rst", core_rst, 0);
        access(0, SIZE_WORD, 32'h0000_0010, 0);
        check("boot16 w16", w16_s, 1);
        give_verdict;
    end
endmodule
`default_nettype wire
